//--- rtl/video_sync_pkg.sv
// Constants, register map and timing counts for the sync measurement block
package video_sync_pkg;
	localparam int          CLK_HZ            = 100_000_000;
	localparam int          CLK_NS            = 1_000_000_000 / CLK_HZ;
	// Register word offsets (index); byte address is four times the index
	localparam logic [7:0]  IDX_FRAME_HIGH    = 8'h0d;
	localparam logic [7:0]  IDX_FRAME_LOW     = 8'h0e;
	localparam logic [7:0]  IDX_LINE_HIGH     = 8'h0f;
	localparam logic [7:0]  IDX_LINE_LOW      = 8'h10;
	localparam logic [7:0]  IDX_CONTROL       = 8'h11;
	localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h12;
	localparam logic [7:0]  IDX_IRQ_MASK      = 8'h13;
	// Control field positions
	localparam int          CTL_TEST_SYNC     = 0;
	localparam int          CTL_BACK_PORCH    = 1;
	localparam int          CTL_CLAMP_OE      = 2;
	localparam logic [2:0]  CTL_RESET         = 3'h0;
	// Interrupt status bit positions
	localparam int          IRQ_FRAME_DONE    = 0;
	localparam int          IRQ_FRAME_OVF     = 1;
	localparam int          IRQ_LINE_DONE     = 2;
	localparam int          IRQ_LINE_OVR      = 3;
	localparam int          IRQ_BITS          = 4;
	// Frame measurement
	localparam int          FRAME_TICK_CYC    = 16;
	localparam int          FRAME_BITS        = 13;
	localparam logic [12:0] FRAME_MAX         = 13'h1fff;
	localparam int          FRAME_OVF_BIT     = 7;
	// Line measurement
	localparam int          LINE_BITS         = 12;
	localparam logic [11:0] LINE_MAX          = 12'hfff;
	localparam int          WINDOW_US         = 32_000;
	localparam int          PERIOD_US         = 32_768;
	localparam int          WINDOW_CYC        = WINDOW_US * 1000 / CLK_NS;
	localparam int          PERIOD_CYC        = PERIOD_US * 1000 / CLK_NS;
	// Test sync timing, ns figures
	localparam int          TH_PERIOD_NS      = 18_000;
	localparam int          TH_LOW_NS         = 2_000;
	localparam int          TV_PERIOD_NS      = 13_823_610;
	localparam int          TV_LOW_NS         = 108_000;
	localparam int          TH_PERIOD_CYC     = TH_PERIOD_NS / CLK_NS;
	localparam int          TH_LOW_CYC        = (TH_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TV_PERIOD_CYC     = TV_PERIOD_NS / CLK_NS;
	localparam int          TV_LOW_CYC        = (TV_LOW_NS + CLK_NS - 1) / CLK_NS;
	// Clamp pulse width in cycles
	localparam int          CLAMP_NS          = 500;
	localparam int          CLAMP_CYC         = (CLAMP_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

//--- rtl/video_sync_measure.sv
// Sync measurement, clamp and test-sync generator with Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module video_sync_measure
	import video_sync_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC,
	parameter int PERIOD_CYCLES = PERIOD_CYC,
	parameter int TV_CYCLES     = TV_PERIOD_CYC
)
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        horiz_sync_in,
	input  wire logic        vert_sync_in,
	output logic             horiz_sync_out,
	output logic             vert_sync_out,
	output logic             shared_port_pin,
	output logic             shared_port_pin_oe,
	output logic             irq
);
	logic [1:0]          hs_sync;
	logic [1:0]          vs_sync;
	logic                hs_d;
	logic                vs_d;
	logic [2:0]          control;
	logic [3:0]          tick_div;
	logic [12:0]         frame_cnt;
	logic                frame_wrap;
	logic [4:0]          frame_high_bits;
	logic [7:0]          frame_buf;
	logic [7:0]          frame_low;
	logic                frame_overflow_flag;
	logic [11:0]         line_cnt;
	logic                line_over_range_flag;
	logic [6:0]          line_high_bits;
	logic [4:0]          line_buf;
	logic [4:0]          line_low;
	logic                line_high_ovr;
	logic [31:0]         win_cnt;
	logic [31:0]         th_cnt;
	logic [31:0]         tv_cnt;
	logic [31:0]         clamp_cnt;
	logic                clamp_pulse;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_event;
	bus_state_t          bus_state;
	logic                hs_rise;
	logic                hs_fall;
	logic                vs_fall;
	logic                tick;
	logic                win_end;
	logic                in_window;
	logic                bus_rd;
	logic                bus_wr;
	logic [7:0]          reg_idx;
	logic [31:0]         next_readdata;

	// Sync inputs come from pins: two flops before use
	// Reset to the idle high level, so no false edge or output pulse follows reset
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			hs_sync <= 2'h3;
			vs_sync <= 2'h3;
			hs_d    <= 1'b1;
			vs_d    <= 1'b1;
		end
		else
		begin
			hs_sync <= {hs_sync[0], horiz_sync_in};
			vs_sync <= {vs_sync[0], vert_sync_in};
			hs_d    <= hs_sync[1];
			vs_d    <= vs_sync[1];
		end
	end

	// Syncs are taken as negative pulses; leading edge is the fall
	assign hs_fall   = hs_d & ~hs_sync[1];
	assign hs_rise   = ~hs_d & hs_sync[1];
	assign vs_fall   = vs_d & ~vs_sync[1];
	assign tick      = (tick_div == 4'(FRAME_TICK_CYC - 1));
	assign win_end   = (win_cnt == PERIOD_CYCLES - 1);
	assign in_window = (win_cnt < WINDOW_CYCLES);
	assign bus_rd    = read && (bus_state == BUS_IDLE);
	// Writes land at the answer edge, where the master sees waitrequest low
	assign bus_wr    = write && (bus_state == BUS_ANSWER);
	assign reg_idx   = address >> 2;

	// Tick prescaler for the frame counter
	always_ff @(posedge mclk)
	begin
		if (!rst_b || vs_fall)
			tick_div <= 4'h0;
		else
			tick_div <= tick_div + 4'h1;
	end

	// Frame counter; saturates once past the top so a slow frame stays flagged
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			frame_cnt  <= 13'h0;
			frame_wrap <= 1'b0;
		end
		else if (vs_fall)
		begin
			frame_cnt  <= 13'h0;
			frame_wrap <= 1'b0;
		end
		else if (tick && !frame_wrap)
		begin
			if (frame_cnt == FRAME_MAX)
				frame_wrap <= 1'b1;
			else
				frame_cnt <= frame_cnt + 13'h1;
		end
	end

	// Frame result transfer and overflow flag
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			frame_high_bits     <= 5'h0;
			frame_buf           <= 8'h0;
			frame_overflow_flag <= 1'b0;
		end
		else if (vs_fall)
		begin
			frame_high_bits     <= frame_cnt[12:8];
			frame_buf           <= frame_cnt[7:0];
			frame_overflow_flag <= frame_wrap;
		end
		else if (tick && !frame_wrap && frame_cnt == FRAME_MAX)
			frame_overflow_flag <= 1'b1;
	end

	// Gate window timer
	always_ff @(posedge mclk)
	begin
		if (!rst_b || win_end)
			win_cnt <= 32'h0;
		else
			win_cnt <= win_cnt + 32'h1;
	end

	// Line counter counts leading edges only inside the gate window
	always_ff @(posedge mclk)
	begin
		if (!rst_b || win_end)
		begin
			line_cnt             <= 12'h0;
			line_over_range_flag <= 1'b0;
		end
		else if (hs_fall && in_window)
		begin
			if (line_cnt == LINE_MAX)
				line_over_range_flag <= 1'b1;
			else
				line_cnt <= line_cnt + 12'h1;
		end
	end

	// Line result transfer; over-range also goes straight to the high byte
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			line_high_bits <= 7'h0;
			line_buf       <= 5'h0;
			line_high_ovr  <= 1'b0;
		end
		else if (win_end)
		begin
			line_high_bits <= line_cnt[11:5];
			line_buf       <= line_cnt[4:0];
			line_high_ovr  <= line_over_range_flag;
		end
		else if (line_over_range_flag)
			line_high_ovr  <= 1'b1;
	end

	// Test sync generators
	always_ff @(posedge mclk)
	begin
		if (!rst_b || !control[CTL_TEST_SYNC])
		begin
			th_cnt <= 32'h0;
			tv_cnt <= 32'h0;
		end
		else
		begin
			th_cnt <= (th_cnt == TH_PERIOD_CYC - 1) ? 32'h0 : th_cnt + 32'h1;
			tv_cnt <= (tv_cnt == TV_CYCLES - 1) ? 32'h0 : tv_cnt + 32'h1;
		end
	end

	// Sync output selection
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			horiz_sync_out <= 1'b1;
			vert_sync_out  <= 1'b1;
		end
		else if (control[CTL_TEST_SYNC])
		begin
			horiz_sync_out <= (th_cnt >= TH_LOW_CYC);
			vert_sync_out  <= (tv_cnt >= TV_LOW_CYC);
		end
		else
		begin
			horiz_sync_out <= hs_sync[1];
			vert_sync_out  <= vs_sync[1];
		end
	end

	// Clamp pulse: fixed width, retriggered by the selected edge
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			clamp_cnt <= 32'h0;
		else if (control[CTL_BACK_PORCH] ? hs_rise : hs_fall)
			clamp_cnt <= 32'(CLAMP_CYC);
		else if (clamp_cnt != 32'h0)
			clamp_cnt <= clamp_cnt - 32'h1;
	end

	assign clamp_pulse = (clamp_cnt != 32'h0);

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			shared_port_pin    <= 1'b0;
			shared_port_pin_oe <= 1'b0;
		end
		else
		begin
			shared_port_pin    <= control[CTL_CLAMP_OE] & clamp_pulse;
			shared_port_pin_oe <= control[CTL_CLAMP_OE];
		end
	end

	// Interrupt events
	always_comb
	begin
		irq_event                 = '0;
		irq_event[IRQ_FRAME_DONE] = vs_fall;
		irq_event[IRQ_FRAME_OVF]  = tick && !frame_wrap && frame_cnt == FRAME_MAX;
		irq_event[IRQ_LINE_DONE]  = win_end;
		irq_event[IRQ_LINE_OVR]   = hs_fall && in_window && line_cnt == LINE_MAX;
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq_status <= '0;
		else if (bus_wr && reg_idx == IDX_IRQ_STATUS && byteenable[0])
			irq_status <= (irq_status & ~writedata[IRQ_BITS-1:0]) | irq_event;
		else
			irq_status <= irq_status | irq_event;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// Writable registers
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			control  <= CTL_RESET;
			irq_mask <= '0;
		end
		else if (bus_wr && byteenable[0])
		begin
			if (reg_idx == IDX_CONTROL)
				control <= writedata[2:0];
			else if (reg_idx == IDX_IRQ_MASK)
				irq_mask <= writedata[IRQ_BITS-1:0];
		end
	end

	// Low bytes are loaded only by a read of their high byte
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			frame_low <= 8'h0;
			line_low  <= 5'h0;
		end
		else if (bus_rd && reg_idx == IDX_FRAME_HIGH)
			frame_low <= frame_buf;
		else if (bus_rd && reg_idx == IDX_LINE_HIGH)
			line_low  <= line_buf;
	end

	// Read mux; unmapped words read zero
	always_comb
	begin
		next_readdata = 32'h0;
		if (reg_idx == IDX_FRAME_HIGH)
			next_readdata = {24'h0, frame_overflow_flag, 2'h0, frame_high_bits};
		else if (reg_idx == IDX_FRAME_LOW)
			next_readdata = {24'h0, frame_low};
		else if (reg_idx == IDX_LINE_HIGH)
			next_readdata = {24'h0, line_high_ovr, line_high_bits};
		else if (reg_idx == IDX_LINE_LOW)
			next_readdata = {27'h0, line_low};
		else if (reg_idx == IDX_CONTROL)
			next_readdata = {29'h0, control};
		else if (reg_idx == IDX_IRQ_STATUS)
			next_readdata = {28'h0, irq_status};
		else if (reg_idx == IDX_IRQ_MASK)
			next_readdata = {28'h0, irq_mask};
	end

	// One wait state: request taken, answer in the next cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			bus_state   <= BUS_IDLE;
			waitrequest <= 1'b1;
			readdata    <= 32'h0;
		end
		else
		begin
			case (bus_state)
				BUS_IDLE:
				begin
					if (read || write)
					begin
						bus_state   <= BUS_ANSWER;
						waitrequest <= 1'b0;
						readdata    <= next_readdata;
					end
				end
				default:
				begin
					bus_state   <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end
endmodule

//--- tb/video_sync_measure_sva.sv
// Checker for the sync measurement block, bound to its ports
`timescale 1ns/10ps
module video_sync_measure_sva
	import video_sync_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  address,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	input  wire logic        waitrequest,
	input  wire logic        horiz_sync_in,
	input  wire logic        vert_sync_in,
	input  wire logic        horiz_sync_out,
	input  wire logic        vert_sync_out,
	input  wire logic        shared_port_pin,
	input  wire logic        shared_port_pin_oe
);
	logic [2:0]  ctl;
	logic [3:0]  age;
	logic [7:0]  hh;
	logic [7:0]  vh;
	logic [15:0] hlow;
	logic [15:0] hper;
	logic [15:0] vlow;
	logic [1:0]  nf;
	logic        hfell;
	logic        hrose;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	assign hfell = |(hh[7:1] & ~hh[6:0]);
	assign hrose = |(~hh[7:1] & hh[6:0]);
	// Control copy; age hides the cycles where design and copy may disagree
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			ctl <= CTL_RESET;
			age <= 4'h0;
		end
		else if (write && !waitrequest && address[7:2] == IDX_CONTROL[5:0] && byteenable[0])
		begin
			ctl <= writedata[2:0];
			age <= 4'h0;
		end
		else if (age != 4'hf)
			age <= age + 4'h1;
	end
	always_ff @(posedge mclk)
	begin
		hh   <= {hh[6:0], horiz_sync_in};
		vh   <= {vh[6:0], vert_sync_in};
		hlow <= horiz_sync_out ? 16'h0 : hlow + 16'h1;
		vlow <= vert_sync_out ? 16'h0 : vlow + 16'h1;
		hper <= $fell(horiz_sync_out) ? 16'h1 : hper + 16'h1;
		nf   <= !ctl[0] ? 2'h0 : ($fell(horiz_sync_out) && nf != 2'h3) ? nf + 2'h1 : nf;
	end
	chk_pin_gated: assert property (!shared_port_pin_oe |-> !shared_port_pin)
		else $error("clamp pin active while its enable is low");
	chk_oe_bit: assert property (age == 4'hf |-> shared_port_pin_oe == ctl[2])
		else $error("clamp enable output differs from control bit");
	chk_clamp_lead: assert property (
		$rose(shared_port_pin) && age == 4'hf && !ctl[1] |-> hfell)
		else $error("clamp pulse without leading sync edge");
	chk_clamp_trail: assert property (
		$rose(shared_port_pin) && age == 4'hf && ctl[1] |-> hrose)
		else $error("clamp pulse without trailing sync edge");
	chk_clamp_width: assert property (
		$rose(shared_port_pin) |-> shared_port_pin[*8] ##42 shared_port_pin ##1 !shared_port_pin)
		else $error("clamp pulse width wrong");
	chk_h_pass: assert property (
		!ctl[0] && age == 4'hf && (hh == 8'h00 || hh == 8'hff) |-> horiz_sync_out == hh[0])
		else $error("line sync not passed through");
	chk_v_pass: assert property (
		!ctl[0] && age == 4'hf && (vh == 8'h00 || vh == 8'hff) |-> vert_sync_out == vh[0])
		else $error("frame sync not passed through");
	chk_th_low: assert property (
		ctl[0] && age == 4'hf && nf == 2'h3 && $rose(horiz_sync_out) |-> hlow == TH_LOW_CYC)
		else $error("test line sync low width wrong");
	chk_th_period: assert property (
		ctl[0] && age == 4'hf && nf >= 2'h2 && $fell(horiz_sync_out) |-> hper == TH_PERIOD_CYC)
		else $error("test line sync period wrong");
	chk_tv_low: assert property (
		ctl[0] && age == 4'hf && $rose(vert_sync_out) |-> vlow == TV_LOW_CYC)
		else $error("test frame sync low width wrong");
endmodule
bind video_sync_measure video_sync_measure_sva chk
(
	.mclk(mclk), .rst_b(rst_b), .address(address), .write(write), .writedata(writedata),
	.byteenable(byteenable), .waitrequest(waitrequest), .horiz_sync_in(horiz_sync_in),
	.vert_sync_in(vert_sync_in), .horiz_sync_out(horiz_sync_out),
	.vert_sync_out(vert_sync_out), .shared_port_pin(shared_port_pin),
	.shared_port_pin_oe(shared_port_pin_oe)
);

//--- tb/sync_source.sv
// Video source model: negative line and frame sync pulses
`timescale 1ns/10ps
module sync_source
(
	input  wire logic        mclk,
	input  wire logic        h_on,
	input  wire logic        v_on,
	input  wire logic [15:0] h_period,
	input  wire logic [15:0] v_period,
	output logic             horiz_sync,
	output logic             vert_sync
);
	logic [15:0] hc;
	logic [15:0] vc;
	initial
	begin
		hc = 16'h0;
		vc = 16'h0;
		horiz_sync = 1'b1;
		vert_sync = 1'b1;
	end
	// Low for half a line, so even a two-cycle line makes one edge per line
	always @(posedge mclk)
	begin
		hc <= (!h_on || hc >= h_period - 16'h1) ? 16'h0 : hc + 16'h1;
		vc <= (!v_on || vc >= v_period - 16'h1) ? 16'h0 : vc + 16'h1;
		horiz_sync <= !(h_on && hc < (h_period >> 1));
		vert_sync <= !(v_on && vc < 16'h28);
	end
endmodule

//--- tb/video_sync_measure_tb.sv
// Self-checking bench for the sync measurement block
`timescale 1ns/10ps
module video_sync_measure_tb
	import video_sync_pkg::*;
;
	localparam int WIN = 9000;
	localparam int TV  = 14000;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  address = 8'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'h1;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        horiz_sync_in;
	logic        vert_sync_in;
	logic        horiz_sync_out;
	logic        vert_sync_out;
	logic        shared_port_pin;
	logic        shared_port_pin_oe;
	logic        irq;
	logic        h_on = 1'b0;
	logic        v_on = 1'b0;
	logic [15:0] hp = 16'h28;
	logic [15:0] vp = 16'h640;
	logic [7:0]  st;
	logic [7:0]  hi;
	logic [7:0]  lo;
	int          n_fail = 0;
	int          num_checks = 0;
	always #5 mclk = ~mclk;
	video_sync_measure #(.WINDOW_CYCLES(WIN), .PERIOD_CYCLES(9216), .TV_CYCLES(TV)) uut
	(
		.mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .horiz_sync_in(horiz_sync_in),
		.vert_sync_in(vert_sync_in), .horiz_sync_out(horiz_sync_out),
		.vert_sync_out(vert_sync_out), .shared_port_pin(shared_port_pin),
		.shared_port_pin_oe(shared_port_pin_oe), .irq(irq)
	);
	sync_source src
	(
		.mclk(mclk), .h_on(h_on), .v_on(v_on), .h_period(hp), .v_period(vp),
		.horiz_sync(horiz_sync_in), .vert_sync(vert_sync_in)
	);
	task automatic wrap_up();
		if (n_fail == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Tick phase against the sync edges leaves one count of slack either way
	function automatic logic [7:0] near(input logic [12:0] got, input int exp);
		return (got + 1 >= exp && got <= exp + 1) ? 8'h1 : 8'h0;
	endfunction
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge mclk);
		address   <= {idx[5:0], 2'b00};
		read      <= !wr;
		write     <= wr;
		writedata <= {24'h0, d};
		@(posedge mclk);
		while (waitrequest !== 1'b0)
			@(posedge mclk);
		q = readdata[7:0];
		read  <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wait_irq(output logic [7:0] s);
		logic [7:0] d;
		while (irq !== 1'b1)
			@(posedge mclk);
		bus(1'b0, IDX_IRQ_STATUS, 8'h0, s);
		bus(1'b1, IDX_IRQ_STATUS, s, d);
		// The level output lags the cleared status by one more cycle
		repeat (2) @(posedge mclk);
	endtask
	initial
	begin
		repeat (95000) @(posedge mclk);
		n_fail++;
		wrap_up();
	end
	initial
	begin
		int nfr;
		int nw;
		void'($urandom(56557));
		nfr = 0;
		nw = 0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		bus(1'b1, IDX_FRAME_HIGH, 8'hff, st);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b0, IDX_FRAME_HIGH + 8'(i), 8'h0, st);
			check(st, 8'h00);
		end
		bus(1'b0, 8'h30, 8'h0, st);
		check(st, 8'h00);
		// Clamp output on before any line edge, so no pulse starts part-way
		bus(1'b1, IDX_CONTROL, 8'h04, st);
		// Half a line above the clamp width, so a pulse never retriggers
		hp   <= 16'(110 + $urandom_range(40));
		vp   <= 16'(1600 + $urandom_range(2400));
		h_on <= 1'b1;
		v_on <= 1'b1;
		bus(1'b1, IDX_IRQ_MASK, 8'h05, st);
		for (int bp = 0; bp < 2; bp++)
		begin
			bus(1'b1, IDX_CONTROL, {5'h0, 1'b1, bp[0], 1'b0}, st);
			// First window and frame started mid-way, so they are skipped
			while (nw < bp + 2)
			begin
				wait_irq(st);
				nfr += int'(st[0] === 1'b1);
				nw += int'(st[2] === 1'b1);
				if (st[0] === 1'b1 && nfr > 1)
				begin
					bus(1'b0, IDX_FRAME_HIGH, 8'h0, hi);
					bus(1'b0, IDX_FRAME_LOW, 8'h0, lo);
					check(hi & 8'he0, 8'h00);
					check(near({hi[4:0], lo}, vp / 16), 8'h1);
				end
				if (st[2] === 1'b1 && nw > 1)
				begin
					bus(1'b0, IDX_LINE_HIGH, 8'h0, hi);
					bus(1'b0, IDX_LINE_LOW, 8'h0, lo);
					check(hi & 8'h80, 8'h00);
					check(lo & 8'he0, 8'h00);
					check(near({hi[6:0], lo[4:0]}, WIN / hp), 8'h1);
				end
			end
		end
		bus(1'b1, IDX_IRQ_MASK, 8'h00, st);
		bus(1'b1, IDX_IRQ_STATUS, 8'hff, st);
		st = 8'h0;
		while (st[0] !== 1'b1)
			bus(1'b0, IDX_IRQ_STATUS, 8'h0, st);
		@(posedge mclk);
		check({7'h0, irq}, 8'h0);
		bus(1'b1, IDX_IRQ_MASK, 8'h01, st);
		repeat (2) @(posedge mclk);
		check({7'h0, irq}, 8'h1);
		h_on <= 1'b0;
		repeat (100) @(posedge mclk);
		bus(1'b1, IDX_CONTROL, 8'h00, st);
		hp   <= 16'h2;
		h_on <= 1'b1;
		bus(1'b1, IDX_IRQ_MASK, 8'h08, st);
		bus(1'b1, IDX_IRQ_STATUS, 8'hff, st);
		repeat (2) @(posedge mclk);
		wait_irq(st);
		check({7'h0, st[3]}, 8'h1);
		bus(1'b0, IDX_LINE_HIGH, 8'h0, hi);
		check({7'h0, hi[7]}, 8'h1);
		h_on <= 1'b0;
		v_on <= 1'b0;
		repeat (100) @(posedge mclk);
		bus(1'b1, IDX_CONTROL, 8'h01, st);
		repeat (2 * TV) @(posedge mclk);
		wrap_up();
	end
endmodule
